// file: verilog/i2c_eeprom_slave.v
// What this block does
// - write-guard high with unlock input clear: no main-array location is ever changed
// - write-guard low or open: writes to the array proceed normally
// - all bus traffic ignored while power-on reset is held
// - reset clears control state and holds the block in standby until release
// - reset asserted again returns the block to standby
// - stop sends block to standby unless a programming cycle runs
// - main array is 2048 bytes in pages of sixteen
// - programming is self-timed from the core clock, at most 4 ms
// - partial pages program only the bytes actually received
// - sixteen-byte id page writable until locked, then read-only forever
// - data line is only pulled low or released, never driven high
// - byte order: slave select, word address, then data bytes
// - write-guard effect disabled while the unlock input is set
// - select byte 1010, three block bits, direction bit (1 = read)
// - page write increments low four address bits only; program at stop
// - slave select not acknowledged while programming, acknowledged after
// - id page selected by upper nibble 1011, middle bits ignored
`include "eeprom_map.vh"
`timescale 1ns/10ps
`default_nettype none

module i2c_eeprom_slave #(
	parameter [`PROG_CNT_W-1:0] PROG_CYCLES = `PROG_CYCLES
) (
	input  wire core_clk_in,
	input  wire rst_in,
	input  wire scl_in,
	input  wire sda_in,
	input  wire wp_in,
	input  wire guard_unlock_in,
	input  wire id_lock_req_in,
	output reg  sda_out,
	output reg  sda_oe_out,
	output reg  busy_out,
	output reg  standby_out
);

	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_RX   = 6'h02;
	localparam [5:0] S_ACK  = 6'h04;
	localparam [5:0] S_TX   = 6'h08;
	localparam [5:0] S_RACK = 6'h10;
	localparam [5:0] S_PROG = 6'h20;

	// 2'b01 main array, 2'b10 id page, 2'b00 not addressed
	function [1:0] sel_kind;
		input [7:0] b;
		begin
			if (b[7:4] == `SEL_MAIN_NIB)
				sel_kind = 2'h1;
			else if (b[7:4] == `SEL_ID_NIB)
				sel_kind = 2'h2;
			else
				sel_kind = 2'h0;
		end
	endfunction

	wire [4:0]               pins_s;
	wire                     scl_s;
	wire                     sda_s;
	wire                     wp_s;
	wire                     unlock_s;
	wire                     lock_req_s;
	reg                      scl_p_q;
	reg                      sda_p_q;
	reg  [5:0]               state_q;
	reg  [3:0]               bit_cnt_q;
	reg  [1:0]               byte_idx_q;
	reg  [7:0]               shift_q;
	reg  [`ADDR_W-1:0]       ptr_q;
	reg                      id_sel_q;
	reg                      rd_q;
	reg  [15:0]              mask_q;
	reg  [`PROG_CNT_W-1:0]   prog_cnt_q;
	reg                      id_lock_q;
	reg  [7:0]               mem [0:`ARRAY_BYTES-1];
	reg  [7:0]               id_mem [0:`PAGE_BYTES-1];
	reg  [7:0]               page_buf [0:`PAGE_BYTES-1];

	pin_sync u_sync (
		.clk_in (core_clk_in),
		.rst_in (rst_in),
		.d_in   ({id_lock_req_in, guard_unlock_in, wp_in, sda_in, scl_in}),
		.q_out  (pins_s)
	);

	assign scl_s      = pins_s[0];
	assign sda_s      = pins_s[1];
	assign wp_s       = pins_s[2];
	assign unlock_s   = pins_s[3];
	assign lock_req_s = pins_s[4];

	wire scl_rise  = scl_s & ~scl_p_q;
	wire scl_fall  = ~scl_s & scl_p_q;
	wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	wire byte_done = (state_q == S_RX) & scl_fall & (bit_cnt_q == `BYTE_BITS);
	wire [1:0] kind = sel_kind(shift_q);
	wire [3:0] prog_idx = prog_cnt_q[3:0];

	// guard only when pin high and not unlocked
	wire main_guarded = wp_s & ~unlock_s;
	// locked or guarded target skips programming
	wire prog_allowed = id_sel_q ? ~id_lock_q : ~main_guarded;

	wire buf_we  = byte_done & (byte_idx_q == 2'h2);
	wire prog_we = (state_q == S_PROG) & (prog_cnt_q < `PAGE_BYTES) & mask_q[prog_idx];
	wire [7:0] rd_byte = id_sel_q ? id_mem[ptr_q[3:0]] : mem[ptr_q];

	// lock is modelled as non-volatile: no reset touches it
	initial id_lock_q = 1'b0;

	always @(posedge core_clk_in) begin
		// lock persists, set only by lock request
		if (lock_req_s)
			id_lock_q <= 1'b1;
		if (buf_we)
			page_buf[ptr_q[3:0]] <= shift_q;
		// only received bytes reach the page
		if (prog_we) begin
			if (id_sel_q)
				id_mem[prog_idx] <= page_buf[prog_idx];
			else
				mem[{ptr_q[`ADDR_W-1:4], prog_idx}] <= page_buf[prog_idx];
		end
	end

	always @(posedge core_clk_in) begin
		scl_p_q     <= scl_s;
		sda_p_q     <= sda_s;
		// data output is a constant low; only the enable moves
		sda_out     <= 1'b0;
		busy_out    <= (state_q == S_PROG);
		standby_out <= (state_q == S_IDLE);
		// reset holds the block in standby, deaf to the bus
		if (rst_in) begin
			state_q     <= S_IDLE;
			bit_cnt_q   <= 4'h0;
			byte_idx_q  <= 2'h0;
			shift_q     <= 8'h00;
			ptr_q       <= 11'h000;
			id_sel_q    <= 1'b0;
			rd_q        <= 1'b0;
			mask_q      <= 16'h0000;
			prog_cnt_q  <= {`PROG_CNT_W{1'b0}};
			sda_oe_out  <= 1'b0;
			busy_out    <= 1'b0;
			standby_out <= 1'b1;
		end else begin
			case (state_q)
				S_IDLE: begin
				end
				S_RX: begin
					if (scl_rise && bit_cnt_q != `BYTE_BITS) begin
						shift_q   <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_done) begin
						bit_cnt_q  <= 4'h0;
						byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h2 : byte_idx_q + 2'h1;
						sda_oe_out <= 1'b1;
						state_q    <= S_ACK;
						// first byte selects, second addresses, rest are data
						if (byte_idx_q == 2'h0) begin
							if (kind == 2'h0) begin
								sda_oe_out <= 1'b0;
								state_q    <= S_IDLE;
							end else begin
								id_sel_q <= kind[1];
								rd_q     <= shift_q[0];
								if (!kind[1])
									ptr_q[10:8] <= shift_q[3:1];
								if (!shift_q[0])
									mask_q <= 16'h0000;
							end
						end else if (byte_idx_q == 2'h1) begin
							ptr_q[7:0] <= shift_q;
						end else begin
							// low four bits wrap inside the page
							mask_q[ptr_q[3:0]] <= 1'b1;
							ptr_q[3:0]         <= ptr_q[3:0] + 4'h1;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						if (rd_q) begin
							shift_q    <= rd_byte;
							sda_oe_out <= ~rd_byte[7];
							state_q    <= S_TX;
							if (id_sel_q)
								ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
							else
								ptr_q <= ptr_q + 11'h001;
						end else begin
							sda_oe_out <= 1'b0;
							state_q    <= S_RX;
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (bit_cnt_q == `TX_LAST_BIT) begin
							sda_oe_out <= 1'b0;
							state_q    <= S_RACK;
						end else begin
							sda_oe_out <= ~shift_q[6];
							shift_q    <= {shift_q[6:0], 1'b0};
							bit_cnt_q  <= bit_cnt_q + 4'h1;
						end
					end
				end
				S_RACK: begin
					// master nack ends the read; wait for stop or start
					if (scl_rise)
						state_q <= sda_s ? S_IDLE : S_ACK;
				end
				S_PROG: begin
					// timed on the core clock, no serial clock needed
					prog_cnt_q <= prog_cnt_q + {{(`PROG_CNT_W-1){1'b0}}, 1'b1};
					if (prog_cnt_q == PROG_CYCLES - {{(`PROG_CNT_W-1){1'b0}}, 1'b1}) begin
						mask_q  <= 16'h0000;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
			// programming ignores the bus, so select gets no ack
			if (state_q != S_PROG) begin
				if (bus_start) begin
					state_q    <= S_RX;
					bit_cnt_q  <= 4'h0;
					byte_idx_q <= 2'h0;
					sda_oe_out <= 1'b0;
				end else if (bus_stop) begin
					sda_oe_out <= 1'b0;
					// program at stop if bytes pending and allowed
					if (|mask_q && prog_allowed) begin
						state_q    <= S_PROG;
						prog_cnt_q <= {`PROG_CNT_W{1'b0}};
					end else begin
						mask_q  <= 16'h0000;
						state_q <= S_IDLE;
					end
				end
			end
		end
	end

endmodule

`default_nettype wire

// file: inc/eeprom_map.vh
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// slave-select upper nibbles
`define SEL_MAIN_NIB   4'ha
`define SEL_ID_NIB     4'hb

// array geometry
`define ARRAY_BYTES    2048
`define ADDR_W         11
`define PAGE_BYTES     16

// self-timed programming cycle
`define CLK_MHZ        100
`define PROG_TIME_US   4000
// PROG_TIME_US times CLK_MHZ, sized to the counter so no bits are dropped
`define PROG_CYCLES    19'h6_1a80
`define PROG_CNT_W     19

// receive bit count at which a byte is complete
`define BYTE_BITS      4'h8
`define TX_LAST_BIT    4'h7

`endif

// file: verilog/pin_sync.v
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire [4:0] d_in,
	output reg  [4:0] q_out
);

	reg [4:0] meta_q;

	always @(posedge clk_in) begin
		if (rst_in) begin
			meta_q <= 5'h00;
			q_out  <= 5'h00;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule

`default_nettype wire

// file: tb/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
	input  wire logic dev_oe_in,
	output var  logic scl_out,
	output wire logic sda_out
);
	logic drv_q;
	// wired-and: the pull-up wins unless a party pulls low
	assign sda_out = drv_q & ~dev_oe_in;
	initial begin
		scl_out = 1'b1;
		drv_q = 1'b1;
	end
	// rate ceiling traded for run time: the bench link runs fast
	// but every level still spans three core edges, enough for the sync
	task automatic st(input logic c, input logic d);
		scl_out = c;
		drv_q = d;
		#31.25;
	endtask
	task automatic start_c;
		st(1'b0, drv_q);
		st(1'b0, 1'b1);
		st(1'b1, 1'b1);
		st(1'b1, 1'b0);
	endtask
	// clock is left high after stop: it stands still between frames
	task automatic stop_c;
		st(1'b0, drv_q);
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		st(1'b1, 1'b1);
	endtask
	// one byte msb first, then the ninth bit both ways
	task automatic xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx, output logic r9);
		logic [8:0] sh;
		sh = {tx, nb};
		for (int i = 8; i >= 0; i--) begin
			st(1'b0, drv_q);
			st(1'b0, sh[i]);
			st(1'b1, sh[i]);
			sh[i] = sda_out;
			st(1'b1, drv_q);
		end
		{rx, r9} = sh;
	endtask
endmodule
`default_nettype wire

// file: tb/eeprom_slave_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_map.vh"
module eeprom_slave_asserts #(
	parameter [`PROG_CNT_W-1:0] PROG_CYCLES = `PROG_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic wp_in,
	input wire logic guard_unlock_in,
	input wire logic id_lock_req_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic busy_out,
	input wire logic standby_out
);
	logic [`PROG_CNT_W-1:0] busy_cnt_q;
	// counted here: a repetition cannot reach the programming length
	always @(posedge core_clk_in) begin
		if (rst_in || !busy_out) begin
			busy_cnt_q <= '0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 1'b1;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	sequence prog_on;
		$rose(busy_out) ##1 busy_out;
	endsequence
	sequence prog_held;
		busy_out [*8];
	endsequence
	never_high_a: assert property (!sda_out) else $error("data line driven high");
	reset_quiet_a: assert property (rst_in |=> !sda_oe_out && !busy_out) else $error("active in reset");
	reset_standby_a: assert property (rst_in |=> standby_out) else $error("no standby in reset");
	busy_standby_a: assert property (disable iff (rst_in)
		busy_out |-> !standby_out) else $error("standby while busy");
	poll_nack_a: assert property (disable iff (rst_in)
		busy_out && $past(busy_out) |-> !sda_oe_out) else $error("ack while busy");
	prog_hold_a: assert property (disable iff (rst_in)
		prog_on |-> prog_held) else $error("programming cut short");
	// busy stands exactly one programming length; the counter holds its final count at the fall
	prog_len_a: assert property (disable iff (rst_in)
		$fell(busy_out) |-> busy_cnt_q == PROG_CYCLES) else $error("wrong programming length");
	done_standby_a: assert property (disable iff (rst_in)
		$fell(busy_out) |-> ##[0:2] standby_out) else $error("no standby after programming");
	guard_block_a: assert property (disable iff (rst_in)
		$rose(busy_out) |-> !(wp_in && $past(wp_in, 8) && !guard_unlock_in && !$past(guard_unlock_in, 8)))
		else $error("programming while guarded");
endmodule
bind i2c_eeprom_slave eeprom_slave_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
	.core_clk_in     (core_clk_in),
	.rst_in          (rst_in),
	.scl_in          (scl_in),
	.sda_in          (sda_in),
	.wp_in           (wp_in),
	.guard_unlock_in (guard_unlock_in),
	.id_lock_req_in  (id_lock_req_in),
	.sda_out         (sda_out),
	.sda_oe_out      (sda_oe_out),
	.busy_out        (busy_out),
	.standby_out     (standby_out)
);
`default_nettype wire

// file: tb/i2c_eeprom_slave_tb.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_slave_tb;
	logic       core_clk_in, rst_in, scl_in, wp_in, guard_unlock_in, id_lock_req_in, nk;
	wire logic  sda_in;
	logic       sda_out, sda_oe_out, busy_out, standby_out;
	logic [7:0] rx;
	int         bad_count, check_count;
	i2c_master_model u_mst (.dev_oe_in(sda_oe_out), .scl_out(scl_in), .sda_out(sda_in));
	i2c_eeprom_slave #(.PROG_CYCLES(19'h0_0190)) u_dut (
		.core_clk_in     (core_clk_in),
		.rst_in          (rst_in),
		.scl_in          (scl_in),
		.sda_in          (sda_in),
		.wp_in           (wp_in),
		.guard_unlock_in (guard_unlock_in),
		.id_lock_req_in  (id_lock_req_in),
		.sda_out         (sda_out),
		.sda_oe_out      (sda_oe_out),
		.busy_out        (busy_out),
		.standby_out     (standby_out)
	);
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic [7:0] b, input logic e);
		u_mst.xfer(b, 1'b1, rx, nk);
		chk({7'h00, nk}, {7'h00, e});
	endtask
	// start clear of the core edge so no pin change lands on it
	task automatic go;
		@(posedge core_clk_in);
		#2;
		u_mst.start_c();
	endtask
	task automatic idle;
		for (int n = 0; n < 600 && standby_out !== 1'b1; n++) @(negedge core_clk_in);
		// a wait that runs out is a mismatch, not a silent return
		chk({7'h00, standby_out}, 8'h01);
	endtask
	task automatic end_w(input logic [7:0] sel, input logic e);
		u_mst.stop_c();
		repeat (8) @(negedge core_clk_in);
		chk({7'h00, busy_out}, {7'h00, e});
		if (e) begin
			go();
			wb(sel, 1'b1);
			idle();
			go();
			wb(sel, 1'b0);
			u_mst.stop_c();
		end
		idle();
	endtask
	task automatic wr(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] d, input logic e);
		go();
		wb(sel, 1'b0);
		wb(a, 1'b0);
		wb(d, 1'b0);
		end_w(sel, e);
	endtask
	task automatic rd(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] exp);
		go();
		wb(sel, 1'b0);
		wb(a, 1'b0);
		u_mst.start_c();
		wb(sel | 8'h01, 1'b0);
		u_mst.xfer(8'hff, 1'b1, rx, nk);
		u_mst.stop_c();
		chk(rx, exp);
	endtask
	task automatic t_guard;
		wr(8'ha6, 8'h25, 8'h5a, 1'b1);
		rd(8'ha6, 8'h25, 8'h5a);
		@(negedge core_clk_in);
		wp_in = 1'b1;
		wr(8'ha6, 8'h25, 8'hc3, 1'b0);
		rd(8'ha6, 8'h25, 8'h5a);
		@(negedge core_clk_in);
		guard_unlock_in = 1'b1;
		wr(8'ha6, 8'h25, 8'h3c, 1'b1);
		rd(8'ha6, 8'h25, 8'h3c);
		@(negedge core_clk_in);
		wp_in = 1'b0;
		guard_unlock_in = 1'b0;
	endtask
	// eighteen bytes from offset 14: the last two land on offsets 14 and 15 again
	task automatic t_page;
		go();
		wb(8'ha0, 1'b0);
		wb(8'h0e, 1'b0);
		for (int i = 0; i < 18; i++) wb(8'h40 + i[7:0], 1'b0);
		end_w(8'ha0, 1'b1);
		for (int o = 0; o < 16; o++) rd(8'ha0, o[7:0], 8'h40 + ((o[7:0] + 8'h02) & 8'h0f) + (o > 13 ? 8'h10 : 8'h00));
		// sequential read: master ack on the first byte keeps the device sending
		go();
		wb(8'ha0, 1'b0);
		wb(8'h0e, 1'b0);
		u_mst.start_c();
		wb(8'ha1, 1'b0);
		u_mst.xfer(8'hff, 1'b0, rx, nk);
		chk(rx, 8'h50);
		u_mst.xfer(8'hff, 1'b1, rx, nk);
		chk(rx, 8'h51);
		u_mst.stop_c();
		idle();
	endtask
	task automatic t_id;
		wr(8'hb6, 8'h02, 8'h77, 1'b1);
		rd(8'hb0, 8'h02, 8'h77);
		@(negedge core_clk_in);
		id_lock_req_in = 1'b1;
		repeat (4) @(negedge core_clk_in);
		id_lock_req_in = 1'b0;
		wr(8'hb6, 8'h02, 8'h11, 1'b0);
	endtask
	task automatic t_reset;
		go();
		wb(8'h96, 1'b1);
		u_mst.stop_c();
		@(negedge core_clk_in);
		rst_in = 1'b1;
		go();
		wb(8'ha6, 1'b1);
		u_mst.stop_c();
		chk({7'h00, standby_out}, 8'h01);
		@(negedge core_clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
		rd(8'hb0, 8'h02, 8'h77);
	endtask
	initial begin
		rst_in = 1'b1;
		wp_in = 1'b0;
		guard_unlock_in = 1'b0;
		id_lock_req_in = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (12) @(negedge core_clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
		t_guard();
		t_page();
		t_id();
		t_reset();
		wrap_up();
	end
	initial begin
		#600_000;
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
